// >>> rci_top.v
// Purpose: reset cause recording and register initialisation
// Assumes: apb slave on pclk, event inputs are asynchronous pins
// Notes:   presetn is the power-on reset; events arrive as pulses
`timescale 1ns/1ps
`include "rci_consts.vh"
// Notes on behaviour
// - power-on sets timeout flag
// - power-on sets power-down flag
// - sleep clear or interrupt wake: to=1 pd=0
// - normal master clear: pc zero, flags kept
// - watchdog reset to=0 pd=1; wake both 0
// - brown-out clears its flag; power-on clears po
// - every true reset zeroes program counter
// - interrupt wake with enable loads vector
// - wake source flag bits get set
// - unimplemented bits read as zero
// - unaffected registers keep contents on resets
module rci_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        brown_out_evt,
  input  wire        master_clear_evt,
  input  wire        watchdog_evt,
  input  wire        wake_int_evt,
  input  wire        sleep_req,
  input  wire [7:0]  wake_src_bits,
  output reg         core_sleeping,
  output reg  [12:0] program_counter,
  output reg         irq
);
  // widening the counter also needs the port and the header constants
  parameter PC_W = 13; // program counter width

  // synchronised event pulses
  wire bo_p; // brown-out pulse
  wire mc_p; // master clear pulse
  wire wd_p; // watchdog timeout pulse
  wire wk_p; // interrupt wake pulse

  // state
  reg [7:0]      core_status_flags;   // core status byte
  reg [1:0]      reset_source_flags;  // brown-out and power-on
  reg [7:0]      core_interrupt_control; // interrupt control
  reg [7:0]      peripheral_flags_one;   // peripheral flags, bit 7 held zero
  reg [7:0]      peripheral_flags_two;   // peripheral flags two
  // scratch stands in for the registers no reset kind touches; power-on
  // gives it zero rather than unknown so reads compare cleanly
  reg [7:0]      scratch;                // unaffected by reset kinds
  reg [`RCI_EV_N-1:0] ev_stat;           // sticky events
  reg [`RCI_EV_N-1:0] ev_en;             // event interrupt enable
  // one-shot so the power-on event sets its status bit exactly once
  reg            por_seen;               // one-shot for power-on event
  reg [PC_W-1:0] next_pc;                // combinational pc

  // apb decode
  // an access counts at the first access-phase edge only: pready is
  // high at the second, so a held request never lands twice
  wire apb_wr = psel & penable & pwrite & ~pready;
  wire apb_rd = psel & penable & ~pwrite & ~pready;
  // register writes need the low byte lane; the clear register does not
  wire wr_lo  = apb_wr & pstrb[0];
  reg  hit;   // offset holds a register

  // offsets that answer without an error
  always @* begin
    case (paddr)
      `RCI_OFF_STATUS:  hit = 1'b1;
      `RCI_OFF_SRCFLG:  hit = 1'b1;
      `RCI_OFF_PC:      hit = 1'b1;
      `RCI_OFF_INTCTL:  hit = 1'b1;
      `RCI_OFF_PFLG1:   hit = 1'b1;
      `RCI_OFF_PFLG2:   hit = 1'b1;
      `RCI_OFF_INIT:    hit = 1'b1;
      `RCI_OFF_EVSTAT:  hit = 1'b1; // read only, writes dropped
      `RCI_OFF_EVCLR:   hit = 1'b1; // write only, reads zero
      `RCI_OFF_EVEN:    hit = 1'b1;
      `RCI_OFF_WAKESRC: hit = 1'b1;
      default:          hit = 1'b0; // refused with pslverr
    endcase
  end

  // classified events, priority: brown-out, clear, watchdog, wake
  // a brown-out swallows a clear in the same cycle: both zero the
  // counter, and only the brown-out has a flag to record it
  wire true_mc   = mc_p & ~bo_p;
  // the watchdog splits on the sleep flag: reset awake, wake asleep
  wire wd_reset  = wd_p & ~core_sleeping & ~bo_p & ~mc_p;
  wire wd_wake   = wd_p &  core_sleeping & ~bo_p & ~mc_p;
  // an interrupt pulse while awake is not ours to act on
  wire int_wake  = wk_p &  core_sleeping & ~bo_p & ~mc_p & ~wd_p;
  // true resets reload controls; wakes only resume
  wire any_reset = bo_p | true_mc | wd_reset;
  wire any_wake  = wd_wake | int_wake;

  // event pins through three-stage synchronisers
  // a pin edge becomes a pulse four edges later: fixed latency traded
  // for immunity to metastability and to one-cycle glitches
  // brown-out detector output
  rci_sync u_bo (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .pin_in     (brown_out_evt),
    .rise_pulse (bo_p)
  );
  // master clear pin, filtered like the others
  rci_sync u_mc (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .pin_in     (master_clear_evt),
    .rise_pulse (mc_p)
  );
  // watchdog expiry from its own oscillator domain
  rci_sync u_wd (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .pin_in     (watchdog_evt),
    .rise_pulse (wd_p)
  );
  // interrupt request that can end sleep
  rci_sync u_wk (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .pin_in     (wake_int_evt),
    .rise_pulse (wk_p)
  );

  // control registers that true resets reload
  // the sequencer only strobes; the values themselves live in u_sfr
  wire [7:0] opt_v;  // option register
  wire [7:0] dir_v;  // port direction
  wire [7:0] per_v;  // timer period
  rci_sfr u_sfr (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .true_reset   (any_reset),
    .wr_en        (wr_lo & (paddr == `RCI_OFF_INIT)),
    .wr_sel       (pwdata[10:8]),
    .wr_data      (pwdata[7:0]),
    .option_cfg   (opt_v),
    .port_dir     (dir_v),
    .timer_period (per_v)
  );

  // next program counter for each reset kind
  // resets beat wakes, and wakes beat a software load in the same cycle
  always @* begin
    // hold unless something below moves it
    next_pc = program_counter;
    if (any_reset)
      next_pc = `RCI_PC_ZERO;
    // the vector only with the global enable set
    else if (int_wake && core_interrupt_control[`RCI_INT_GIE])
      next_pc = `RCI_PC_VECTOR;
    // otherwise a wake resumes at the next address
    else if (any_wake)
      next_pc = program_counter + 13'h0001;
    else if (wr_lo && paddr == `RCI_OFF_PC)
      next_pc = pwdata[PC_W-1:0]; // software load
  end

  // status flags, reset source and pc
  // later assignments win: software writes, then sleep entry, then
  // the event chain, so an event never loses to a same-cycle write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_status_flags  <= 8'h18;
      reset_source_flags <= 2'h0;
      program_counter    <= `RCI_PC_ZERO;
      // power-on starts awake, with the one-shot armed
      core_sleeping      <= 1'b0;
      por_seen           <= 1'b0;
    end else if (clk_en) begin
      por_seen        <= 1'b1;
      program_counter <= next_pc;
      // software writes first, events override below
      if (wr_lo && paddr == `RCI_OFF_STATUS)
        core_status_flags <= {pwdata[7:5], core_status_flags[4:3],
                              pwdata[2:0]};
      if (wr_lo && paddr == `RCI_OFF_SRCFLG)
        reset_source_flags <= pwdata[1:0];
      // sleep entry marks timeout set and power-down clear up front;
      // a clear during sleep then writes the same pair again
      if (sleep_req && !core_sleeping && !any_reset) begin
        core_sleeping <= 1'b1;
        core_status_flags[`RCI_ST_TO] <= 1'b1;
        core_status_flags[`RCI_ST_PD] <= 1'b0;
      end
      // brown-out: both flags set, its own source flag cleared
      if (bo_p) begin
        core_status_flags <= {3'h0, 2'h3, core_status_flags[2:0]};
        reset_source_flags[`RCI_SRC_BO] <= 1'b0;
        core_sleeping <= 1'b0;
      end else if (true_mc) begin
        // asleep the flags read as a sleep clear, awake they are kept
        core_sleeping <= 1'b0;
        if (core_sleeping)
          core_status_flags <= {3'h0, 2'h2, core_status_flags[2:0]};
        else
          core_status_flags <= {3'h0, core_status_flags[4:0]};
      end else if (wd_reset) begin
        // the sleep flag stays: this branch only runs awake
        core_status_flags <= {3'h0, 2'h1, core_status_flags[2:0]};
      end else if (wd_wake) begin
        // upper status bits are left as they are
        core_sleeping <= 1'b0;
        core_status_flags[`RCI_ST_TO] <= 1'b0;
        core_status_flags[`RCI_ST_PD] <= 1'b0;
      end else if (int_wake) begin
        // same flag image as a clear during sleep
        core_sleeping <= 1'b0;
        core_status_flags[`RCI_ST_TO] <= 1'b1;
        core_status_flags[`RCI_ST_PD] <= 1'b0;
      end
    end
  end

  // interrupt control and peripheral flags
  // the reserved bit of flags one is forced clear on every path, so
  // neither a software write nor the wake path can set it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_interrupt_control <= `RCI_ZERO8;
      peripheral_flags_one   <= `RCI_ZERO8;
      peripheral_flags_two   <= `RCI_ZERO8;
      scratch                <= `RCI_ZERO8;
    end else if (clk_en) begin
      // plain software writes first; reset and wake below override them
      if (wr_lo && paddr == `RCI_OFF_INTCTL)
        core_interrupt_control <= pwdata[7:0];
      if (wr_lo && paddr == `RCI_OFF_PFLG1)
        peripheral_flags_one <= {1'b0, pwdata[6:0]};
      if (wr_lo && paddr == `RCI_OFF_PFLG2)
        peripheral_flags_two <= pwdata[7:0];
      if (wr_lo && paddr == `RCI_OFF_WAKESRC)
        scratch <= pwdata[7:0];
      // resets clear both flag bytes and the global enable with them
      if (any_reset) begin
        core_interrupt_control <= `RCI_ZERO8;
        peripheral_flags_one   <= `RCI_ZERO8;
        peripheral_flags_two   <= `RCI_ZERO8;
      end else if (any_wake) begin
        // wake source bits win over a same-cycle write
        peripheral_flags_one <= peripheral_flags_one |
                                {1'b0, wake_src_bits[6:0]};
        // the flag byte that records the cause depends on the source
        if (int_wake)
          core_interrupt_control[0] <= 1'b1;
        else
          peripheral_flags_two[0] <= 1'b1;
      end
    end
  end

  // sticky event status, set wins over clear
  // bit 0 latches the first enabled edge after power-on release
  // write-one-to-clear ignores the byte lanes, unlike the other writes
  wire [`RCI_EV_N-1:0] ev_set = {any_wake, wd_reset, true_mc, bo_p,
                                 ~por_seen};
  // clear strobes from a write to the clear register
  wire [`RCI_EV_N-1:0] ev_clr = (apb_wr && paddr == `RCI_OFF_EVCLR) ?
                                pwdata[`RCI_EV_N-1:0] : {`RCI_EV_N{1'b0}};
  // status bits repeat per event, so one generate loop builds them
  genvar gi;
  generate
    for (gi = 0; gi < `RCI_EV_N; gi = gi + 1) begin : g_ev
      // one sticky bit per event
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          ev_stat[gi] <= 1'b0;
        else if (clk_en)
          ev_stat[gi] <= ev_set[gi] | (ev_stat[gi] & ~ev_clr[gi]);
      end
    end
  endgenerate

  // enable register and interrupt line
  // irq is registered so the output comes from a flip-flop; it lags
  // the status bit by one edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_en <= {`RCI_EV_N{1'b0}};
      irq   <= 1'b0;
    end else if (clk_en) begin
      if (wr_lo && paddr == `RCI_OFF_EVEN)
        ev_en <= pwdata[`RCI_EV_N-1:0];
      // level output, high while an enabled status bit stays set
      irq <= |(ev_stat & ev_en);
    end
  end

  // apb answer: one wait state, zero data when unmapped
  // prdata holds its last value between accesses; a write clears it
  // so stale read data never rides on a later write answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      // the answer is a single-cycle pulse: no access lands while pready is high
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (apb_wr || apb_rd) begin
        pready  <= 1'b1;
        pslverr <= ~hit;
        prdata  <= 32'h0000_0000;
        if (apb_rd) begin
          // unlisted bits stay zero from the clear above
          case (paddr)
            `RCI_OFF_STATUS:  prdata[7:0] <= core_status_flags;
            `RCI_OFF_SRCFLG:  prdata[1:0] <= reset_source_flags;
            `RCI_OFF_PC:      prdata[PC_W-1:0] <= program_counter;
            `RCI_OFF_INTCTL:  prdata[7:0] <= core_interrupt_control;
            `RCI_OFF_PFLG1:   prdata[7:0] <= peripheral_flags_one;
            `RCI_OFF_PFLG2:   prdata[7:0] <= peripheral_flags_two;
            `RCI_OFF_INIT:    prdata[23:0] <= {per_v, dir_v, opt_v};
            `RCI_OFF_EVSTAT:  prdata[`RCI_EV_N-1:0] <= ev_stat;
            `RCI_OFF_EVEN:    prdata[`RCI_EV_N-1:0] <= ev_en;
            `RCI_OFF_WAKESRC: prdata[7:0] <= scratch;
            default:          prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule // rci_top

// >>> rci_consts.vh
// Purpose: shared constants for the reset cause and init state block
// Assumes: 32-bit apb data, word aligned registers
// Notes:   offsets are byte addresses
`ifndef RCI_CONSTS_VH
`define RCI_CONSTS_VH
// register byte offsets
`define RCI_OFF_STATUS   12'h000
`define RCI_OFF_SRCFLG   12'h004
`define RCI_OFF_PC       12'h008
`define RCI_OFF_INTCTL   12'h00c
`define RCI_OFF_PFLG1    12'h010
`define RCI_OFF_PFLG2    12'h014
`define RCI_OFF_INIT     12'h018
`define RCI_OFF_EVSTAT   12'h01c
`define RCI_OFF_EVCLR    12'h020
`define RCI_OFF_EVEN     12'h024
`define RCI_OFF_WAKESRC  12'h028
// core status flag bit positions
`define RCI_ST_PD        3
`define RCI_ST_TO        4
// reset source flag bit positions
`define RCI_SRC_BO       0
`define RCI_SRC_PO       1
// control bit positions
`define RCI_INT_GIE      7
`define RCI_PF1_RSV      7
// reset and vector values
`define RCI_PC_ZERO      13'h0000
`define RCI_PC_VECTOR    13'h0004
`define RCI_ALL_ONES     8'hff
`define RCI_ZERO8        8'h00
// event bit positions in the event status register
`define RCI_EV_POR       0
`define RCI_EV_BOR       1
`define RCI_EV_MASTER_CLEAR_RESET      2
`define RCI_EV_WDOG      3
`define RCI_EV_WAKE      4
`define RCI_EV_N         5
`endif

// >>> rci_sync.v
// Purpose: three-stage synchroniser with agreement check on an event pin
// Assumes: input is asynchronous to pclk
// Notes:   emits a one-cycle pulse on an agreed rising change
`timescale 1ns/1ps
module rci_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire clk_en,
  input  wire pin_in,
  output reg  rise_pulse
);
  reg s1; // first stage, read by s2 only
  reg s2; // second stage
  reg s3; // third stage
  reg lvl; // agreed level

  // shift chain, change counts when s2 and s3 agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1         <= 1'b0;
      s2         <= 1'b0;
      s3         <= 1'b0;
      lvl        <= 1'b0;
      rise_pulse <= 1'b0;
    end else if (clk_en) begin
      s1         <= pin_in;
      s2         <= s1;
      s3         <= s2;
      rise_pulse <= 1'b0;
      if (s2 == s3) begin
        lvl        <= s3;
        rise_pulse <= s3 & ~lvl;
      end
    end
  end
endmodule // rci_sync

// >>> rci_sfr.v
// Purpose: control registers that the reset kinds reinitialise
// Assumes: load strobe from the sequencer, one cycle wide
// Notes:   master clear and watchdog reset load as power-on does
`timescale 1ns/1ps
`include "rci_consts.vh"
module rci_sfr (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clk_en,
  input  wire       true_reset,
  input  wire       wr_en,
  input  wire [2:0] wr_sel,
  input  wire [7:0] wr_data,
  output reg  [7:0] option_cfg,
  output reg  [7:0] port_dir,
  output reg  [7:0] timer_period
);
  // option, direction and period all come back as ones
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_cfg   <= `RCI_ALL_ONES;
      port_dir     <= `RCI_ALL_ONES;
      timer_period <= `RCI_ALL_ONES;
    end else if (clk_en) begin
      if (true_reset) begin
        option_cfg   <= `RCI_ALL_ONES;
        port_dir     <= `RCI_ALL_ONES;
        timer_period <= `RCI_ALL_ONES;
      end else if (wr_en) begin
        case (wr_sel)
          3'h0:    option_cfg   <= wr_data;
          3'h1:    port_dir     <= wr_data;
          3'h2:    timer_period <= wr_data;
          default: option_cfg   <= option_cfg;
        endcase
      end
    end
  end
endmodule // rci_sfr

// >>> rci_top_checker.sv
// Purpose: port-level checks for the reset cause block
// Assumes: clk_en held high by the bench
// Notes:   apb answer after one wait state; events pass a pin synchroniser
`timescale 1ns/1ps
module rci_top_checker #(parameter PC_W = 13) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        master_clear_evt,
  input wire        watchdog_evt,
  input wire        wake_int_evt,
  input wire        sleep_req,
  input wire        core_sleeping,
  input wire [PC_W-1:0] program_counter
);
  // single domain, power-on reset silences everything
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // answer is a one-cycle pulse
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held over a cycle");
  // error flag only rides on the answer
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // exactly one wait state after the access edge
  answer_next_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  // no answer without an access phase before it
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("apb answer without access");
  // unmapped read is refused and returns zero
  unmapped_zero_a: assert property (
    pready && !pwrite && paddr > 12'h028 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  // counter starts at zero after power-on
  reset_pc_zero_a: assert property (
    !$past(presetn) |-> program_counter == 13'h0000)
    else $error("counter not zero after power-on");
  // master clear zeroes the counter within the sync delay
  clear_pc_zero_a: assert property (
    $rose(master_clear_evt) |-> ##[1:8] program_counter == 13'h0000)
    else $error("counter not zero after master clear");
  // awake watchdog expiry is a true reset
  wdog_pc_zero_a: assert property (
    !core_sleeping && $rose(watchdog_evt) |->
      ##[1:8] program_counter == 13'h0000)
    else $error("counter not zero after watchdog reset");
  // sleep is only entered on request
  sleep_cause_a: assert property (
    $rose(core_sleeping) |-> $past(sleep_req))
    else $error("sleep entered without request");
  // interrupt wake leaves sleep in bounded time
  wake_exit_a: assert property (
    core_sleeping && $rose(wake_int_evt) |-> ##[1:8] !core_sleeping)
    else $error("no wake after interrupt");
endmodule // rci_top_checker
bind rci_top rci_top_checker #(.PC_W(PC_W)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .master_clear_evt(master_clear_evt), .watchdog_evt(watchdog_evt),
  .wake_int_evt(wake_int_evt), .sleep_req(sleep_req),
  .core_sleeping(core_sleeping), .program_counter(program_counter));

// >>> test_rci_top.sv
// Purpose: self-checking bench for the reset cause block
// Assumes: clk_en and byte strobes held high
// Notes:   model tracks flags, counter and sleep per event kind
`timescale 1ns/1ps
`include "rci_consts.vh"
module test_rci_top;
  reg         pclk, presetn, clk_en, psel, penable, pwrite, sleep_req;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg  [3:0]  pstrb;
  reg         bo_e, mc_e, wd_e, wk_e;  // event pins
  reg  [7:0]  wake_src_bits;
  wire [31:0] prdata;
  wire        pready, pslverr, core_sleeping, irq;
  wire [12:0] program_counter;
  logic [31:0] rd, w, seed = 32'h874cab02;
  logic        er;
  int n_mismatch = 0, num_checks = 0;
  int m_to = 1, m_pd = 1, m_po = 0, m_bo = 0;  // model flags
  int m_pc = 0, m_sl = 0, m_gie = 0, m_pf = 0;  // model state
  rci_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brown_out_evt(bo_e), .master_clear_evt(mc_e), .watchdog_evt(wd_e),
    .wake_int_evt(wk_e), .sleep_req(sleep_req), .wake_src_bits(wake_src_bits),
    .core_sleeping(core_sleeping), .program_counter(program_counter),
    .irq(irq));
  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task results();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // xorshift source, fixed start
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one apb transfer; request held until pready seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; the hang guard ends a wait that never ends
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);  // idle gap avoids a double drive
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // compare flags, counter and sleep state with the model
  task state();
    rchk(`RCI_OFF_STATUS, 32'h18, (m_to << 4) | (m_pd << 3));
    rchk(`RCI_OFF_PC, 32'h1fff, m_pc & 32'h1fff);
    rchk(`RCI_OFF_SRCFLG, 32'h3, (m_po << 1) | m_bo);
    chk({31'h0, core_sleeping}, m_sl);
  endtask
  // request sleep for one cycle
  task slp();
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge pclk);
    m_sl = 1;
    m_to = 1;
    m_pd = 0;
  endtask
  // k: 1 brown-out, 2 master clear, 3 watchdog, 4 interrupt wake
  task ev(input int k);
    bo_e <= (k == 1);
    mc_e <= (k == 2);
    wd_e <= (k == 3);
    wk_e <= (k == 4);
    repeat (6) @(posedge pclk);  // long enough for the pin filter
    {bo_e, mc_e, wd_e, wk_e} <= 4'h0;
    repeat (8) @(posedge pclk);
    if (k < 3 || (k == 3 && m_sl == 0)) begin
      m_gie = 0;  // true reset
      m_pf = 0;
    end
    if (k == 1) m_bo = 0;
    case (k)
      1: begin
        m_to = 1;
        m_pd = 1;
      end
      2: begin
        m_to = m_sl ? 1 : m_to;
        m_pd = m_sl ? 0 : m_pd;
      end
      3: begin
        m_pd = m_sl ? 0 : 1;
        m_to = 0;
      end
      default: m_pc = m_gie ? 4 : m_pc + 1;
    endcase
    if (k < 4) m_pc = m_sl && k == 3 ? m_pc + 1 : 0;
    m_sl = 0;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    results();
  end
  initial begin
    {psel, penable, pwrite, bo_e, mc_e, wd_e, wk_e, sleep_req} = 8'h0;
    {paddr, pwdata, wake_src_bits} = 52'h0;
    pstrb = 4'hf;
    clk_en = 1'b1;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    state();
    rchk(`RCI_OFF_EVSTAT, 32'h1f, 32'h01);
    rchk(`RCI_OFF_INIT, 32'hffffff, 32'hffffff);
    apb(1'b1, `RCI_OFF_PFLG1, 32'h7f);
    rchk(`RCI_OFF_PFLG1, 32'hffffffff, 32'h7f);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, er}, 32'h1);
    w = rnd();
    apb(1'b1, `RCI_OFF_WAKESRC, w);
    apb(1'b1, `RCI_OFF_INIT, 32'h05a);
    apb(1'b1, `RCI_OFF_SRCFLG, 32'h3);
    m_po = 1;
    m_bo = 1;
    m_pc = rnd() & 32'h1fff;
    apb(1'b1, `RCI_OFF_PC, m_pc);
    ev(3);
    state();
    rchk(`RCI_OFF_INIT, 32'hffffff, 32'hffffff);
    rchk(`RCI_OFF_WAKESRC, 32'hff, w & 32'hff);
    ev(2);
    state();
    ev(1);
    state();
    rchk(`RCI_OFF_EVSTAT, 32'h1f, 32'h0f);
    slp();
    state();
    m_pc = rnd() & 32'h1fff;
    apb(1'b1, `RCI_OFF_PC, m_pc);
    ev(3);
    state();
    rchk(`RCI_OFF_PFLG2, 32'h1, 32'h1);
    apb(1'b1, `RCI_OFF_EVEN, 32'h10);
    // interrupt wake without, then with, the global enable
    for (int g = 0; g < 2; g++) begin
      m_gie = g;
      apb(1'b1, `RCI_OFF_INTCTL, g << 7);
      slp();
      w = rnd();
      wake_src_bits <= w[7:0] | 8'h80;
      m_pf |= w & 32'h7f;
      m_pc = rnd() & 32'h1fff;
      apb(1'b1, `RCI_OFF_PC, m_pc);
      ev(4);
      state();
      rchk(`RCI_OFF_INTCTL, 32'h1, 32'h1);
      rchk(`RCI_OFF_PFLG1, 32'hff, m_pf);
      chk({31'h0, irq}, 32'h1);
      // first pass clears the event, second masks it
      apb(1'b1, g ? `RCI_OFF_EVEN : `RCI_OFF_EVCLR, g ? 32'h0 : 32'h10);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    slp();
    ev(2);
    state();
    rchk(`RCI_OFF_INTCTL, 32'hff, 32'h0);
    results();
  end
endmodule // test_rci_top
